// [rtl/sbh_sideband.sv]
// Notes on behaviour
// - an accepted management request first saves state, then enters handler mode.
// - in handler mode an acknowledge is sent on the bus before handler fetch begins.
// - a management request held while reset releases floats every output.
// - a clock-halt request enters halt-grant and sends a halt acknowledge.
// - in halt-grant only the bus interface and local interrupt clocks keep running.
// - in halt-grant snoops and interrupts are still serviced.
// - releasing clock-halt restores all clocks and resumes execution.
// - the clock-halt request is asynchronous and never touches the bus clock.
// - a deeper-halt request in halt-grant enters sleep, and its release returns to halt-grant.
`timescale 1ns/100ps
`default_nettype none
module sbh_sideband
	import sbh_pkg::*;
#(
	parameter int unsigned SYNC_STAGES = sbh_pkg::SBH_SYNC_STAGES,
	parameter int unsigned SAVE_CYCLES = sbh_pkg::SBH_SAVE_CYCLES
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic                 mgmt_interrupt_req_n,
	input  wire logic                 clock_halt_req_n,
	input  wire logic                 deeper_halt_req_n,
	input  wire logic                 ack_done,
	input  wire logic                 save_done,
	input  wire logic                 handler_exit,
	input  wire logic                 snoop_req,
	input  wire logic                 intr_req,
	output var  sbh_pkg::sbh_ack_req_t ack_req,
	output var  sbh_pkg::sbh_clk_en_t  clk_en,
	output var  logic                 save_start,
	output var  logic                 handler_fetch,
	output var  logic                 exec_en,
	output var  logic                 outputs_oe,
	output var  logic                 snoop_resp,
	output var  logic                 intr_service,
	output var  logic                 in_handler_mode
);
	import sbh_pkg::*;

	// the save counter is sixteen bits wide
	if (SAVE_CYCLES < 1 || SAVE_CYCLES > 65536) begin : g_bad_save
		$error("save cycle count out of range");
	end

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	logic mgmt_n_s;
	logic halt_n_s;
	logic deep_n_s;

	// requests come straight from pins with no clock relation
	// only the management one is kept out of reset so the release strap sees a request held through it
	sbh_sync #(.STAGES(SYNC_STAGES), .INIT(1'b1)) u_sync_mgmt (
		.core_clk (core_clk),
		.rst      (1'b0),
		.d_in     (mgmt_interrupt_req_n),
		.q_out    (mgmt_n_s)
	);
	sbh_sync #(.STAGES(SYNC_STAGES), .INIT(1'b1)) u_sync_halt (
		.core_clk (core_clk),
		.rst      (rst),
		.d_in     (clock_halt_req_n),
		.q_out    (halt_n_s)
	);
	sbh_sync #(.STAGES(SYNC_STAGES), .INIT(1'b1)) u_sync_deep (
		.core_clk (core_clk),
		.rst      (rst),
		.d_in     (deeper_halt_req_n),
		.q_out    (deep_n_s)
	);

	// ----------------------------------------------------------------
	// reset-release strap
	// ----------------------------------------------------------------
	logic rst_d_r;
	logic rst_d_nxt;
	logic float_r;
	logic float_nxt;

	// caught at the first clock after release, never under reset itself
	always_comb begin
		rst_d_nxt = rst;
		float_nxt = float_r;
		if (rst_d_r && !rst) begin
			float_nxt = !mgmt_n_s;
		end
	end

	always_ff @(posedge core_clk) begin
		rst_d_r <= rst_d_nxt;
		float_r <= float_nxt;
	end

	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	sbh_state_t            st_r;
	sbh_state_t            st_nxt;
	logic [15:0]           cnt_r;
	logic [15:0]           cnt_nxt;
	sbh_ack_req_t          ack_r;
	sbh_ack_req_t          ack_nxt;
	logic                  halt_ackd_r;
	logic                  halt_ackd_nxt;

	localparam logic [15:0] SAVE_LAST = 16'(SAVE_CYCLES - 1);

	always_comb begin
		st_nxt        = st_r;
		cnt_nxt       = cnt_r;
		ack_nxt       = ack_r;
		halt_ackd_nxt = halt_ackd_r;
		if (ack_r.valid && ack_done) begin
			ack_nxt.valid = 1'b0;
			ack_nxt.kind  = SBH_ACK_NONE;
		end
		unique case (st_r)
			SBH_RUN: begin
				// management request takes priority over clock halt
				if (!mgmt_n_s) begin
					st_nxt  = SBH_SAVE;
					cnt_nxt = '0;
				end else if (!halt_n_s) begin
					st_nxt        = SBH_HALT;
					halt_ackd_nxt = 1'b0;
				end
			end
			SBH_SAVE: begin
				// state must be stored before the handler may run
				if (save_done && cnt_r >= SAVE_LAST) begin
					st_nxt        = SBH_HND_ACK;
					ack_nxt.valid = 1'b1;
					ack_nxt.kind  = SBH_ACK_MGMT;
				end else if (cnt_r < SAVE_LAST) begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end
			SBH_HND_ACK: begin
				if (ack_r.valid && ack_done) begin
					st_nxt = SBH_HND_RUN;
				end
			end
			SBH_HND_RUN: begin
				if (handler_exit) begin
					st_nxt = SBH_RUN;
				end
			end
			SBH_HALT: begin
				if (!halt_ackd_r && !ack_r.valid) begin
					ack_nxt.valid = 1'b1;
					ack_nxt.kind  = SBH_ACK_HALT;
					halt_ackd_nxt = 1'b1;
				end
				// sleep only once the acknowledge has left the bus
				if (halt_n_s && halt_ackd_r && !ack_r.valid) begin
					st_nxt = SBH_RUN;
				end else if (!deep_n_s && halt_ackd_r && !ack_r.valid) begin
					st_nxt = SBH_SLEEP;
				end
			end
			SBH_SLEEP: begin
				if (deep_n_s) begin
					st_nxt = SBH_HALT;
				end
			end
			default: begin
				st_nxt = SBH_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r        <= SBH_RUN;
			cnt_r       <= '0;
			ack_r       <= '0;
			halt_ackd_r <= 1'b0;
		end else begin
			st_r        <= st_nxt;
			cnt_r       <= cnt_nxt;
			ack_r       <= ack_nxt;
			halt_ackd_r <= halt_ackd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	sbh_clk_en_t clk_nxt;
	logic        save_nxt;
	logic        fetch_nxt;
	logic        exec_nxt;
	logic        snp_nxt;
	logic        intr_nxt;
	logic        hnd_nxt;

	always_comb begin
		clk_nxt.core_en   = !(st_nxt inside {SBH_HALT, SBH_SLEEP});
		clk_nxt.bus_if_en = (st_nxt != SBH_SLEEP);
		clk_nxt.lint_en   = (st_nxt != SBH_SLEEP);
		save_nxt  = (st_nxt == SBH_SAVE);
		fetch_nxt = (st_nxt == SBH_HND_RUN);
		exec_nxt  = (st_nxt inside {SBH_RUN, SBH_HND_RUN});
		hnd_nxt   = (st_nxt inside {SBH_HND_ACK, SBH_HND_RUN});
		// sleep ignores snoops and interrupts, halt-grant does not
		snp_nxt   = snoop_req && (st_r != SBH_SLEEP);
		intr_nxt  = intr_req && (st_r != SBH_SLEEP);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			clk_en          <= '1;
			save_start      <= 1'b0;
			handler_fetch   <= 1'b0;
			exec_en         <= 1'b0;
			snoop_resp      <= 1'b0;
			intr_service    <= 1'b0;
			in_handler_mode <= 1'b0;
			outputs_oe      <= 1'b0;
			ack_req         <= '0;
		end else begin
			clk_en          <= clk_nxt;
			save_start      <= save_nxt;
			handler_fetch   <= fetch_nxt;
			exec_en         <= exec_nxt;
			snoop_resp      <= snp_nxt;
			intr_service    <= intr_nxt;
			in_handler_mode <= hnd_nxt;
			outputs_oe      <= !float_nxt;
			ack_req         <= ack_nxt;
		end
	end
endmodule : sbh_sideband
`default_nettype wire

// [rtl/sbh_pkg.sv]
`default_nettype none
package sbh_pkg;

	// ----------------------------------------------------------------
	// power and handler states
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		SBH_RUN       = 6'h01,
		SBH_SAVE      = 6'h02,
		SBH_HND_ACK   = 6'h04,
		SBH_HND_RUN   = 6'h08,
		SBH_HALT      = 6'h10,
		SBH_SLEEP     = 6'h20
	} sbh_state_t;

	// ----------------------------------------------------------------
	// bus special-cycle announcements
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SBH_ACK_NONE  = 2'h0,
		SBH_ACK_MGMT  = 2'h1,
		SBH_ACK_HALT  = 2'h2
	} sbh_ack_t;

	typedef struct packed {
		logic     valid;
		sbh_ack_t kind;
	} sbh_ack_req_t;

	// clocks gated per unit
	typedef struct packed {
		logic core_en;
		logic bus_if_en;
		logic lint_en;
	} sbh_clk_en_t;

	localparam int unsigned SBH_SYNC_STAGES = 2;
	localparam int unsigned SBH_SAVE_CYCLES = 4;

endpackage : sbh_pkg
`default_nettype wire

// [rtl/sbh_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module sbh_sync #(
	parameter int unsigned STAGES = 2,
	parameter logic        INIT   = 1'b1
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic d_in,
	output var  logic q_out
);
	logic [STAGES-1:0] sh_r;
	logic [STAGES-1:0] sh_nxt;

	if (STAGES < 2) begin : g_bad_stages
		$error("sbh_sync needs two stages or more");
	end

	// first stage feeds only the next stage
	always_comb begin
		sh_nxt = {sh_r[STAGES-2:0], d_in};
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sh_r <= {STAGES{INIT}};
		end else begin
			sh_r <= sh_nxt;
		end
	end

	assign q_out = sh_r[STAGES-1];
endmodule : sbh_sync
`default_nettype wire

// [verification/sbh_sideband_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module sbh_sideband_check
	import sbh_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  mgmt_interrupt_req_n,
	input  wire logic                  clock_halt_req_n,
	input  wire logic                  deeper_halt_req_n,
	input  wire logic                  ack_done,
	input  wire logic                  snoop_req,
	input  wire logic                  intr_req,
	input  wire sbh_pkg::sbh_ack_req_t ack_req,
	input  wire sbh_pkg::sbh_clk_en_t  clk_en,
	input  wire logic                  save_start,
	input  wire logic                  handler_fetch,
	input  wire logic                  exec_en,
	input  wire logic                  outputs_oe,
	input  wire logic                  snoop_resp,
	input  wire logic                  intr_service,
	input  wire logic                  in_handler_mode
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence run_s;
		exec_en && !in_handler_mode && !save_start;
	endsequence
	sequence halted_s;
		!clk_en.core_en && !ack_req.valid && !$past(clk_en.core_en);
	endsequence
	mgmt_sync_a: assert property (
		run_s ##0 $fell(mgmt_interrupt_req_n)
		|-> !save_start[*2] ##[1:3] save_start)
		else $error("mgmt entry timing");
	save_ack_a: assert property (
		$rose(ack_req.valid) && ack_req.kind == SBH_ACK_MGMT
		|-> $past(save_start)) else $error("ack before save");
	ack_fetch_a: assert property (
		$rose(handler_fetch) |-> in_handler_mode && !ack_req.valid
		&& ($past(ack_done) || $past(ack_done, 2)))
		else $error("fetch before ack");
	float_hold_a: assert property (
		!outputs_oe && !$past(rst) |=> !outputs_oe)
		else $error("float not sticky");
	halt_gate_a: assert property (
		run_s ##0 mgmt_interrupt_req_n ##0 $fell(clock_halt_req_n)
		|-> ##[2:5] !clk_en.core_en) else $error("halt entry");
	unit_clk_a: assert property (
		ack_req.valid && ack_req.kind == SBH_ACK_HALT |-> !clk_en.core_en
		&& clk_en.bus_if_en && clk_en.lint_en) else $error("unit clocks");
	snoop_kept_a: assert property (
		snoop_req && clk_en.bus_if_en ##1 clk_en.bus_if_en
		|-> snoop_resp) else $error("snoop lost");
	intr_kept_a: assert property (
		intr_req && clk_en.lint_en ##1 clk_en.lint_en
		|-> intr_service) else $error("interrupt lost");
	halt_exit_a: assert property (
		halted_s ##0 deeper_halt_req_n ##0 $rose(clock_halt_req_n)
		|-> ##[2:5] clk_en.core_en && exec_en) else $error("no resume");
	sleep_entry_a: assert property (
		halted_s ##0 !clock_halt_req_n ##0 $fell(deeper_halt_req_n)
		|-> ##[2:5] !clk_en.bus_if_en) else $error("no sleep");
endmodule : sbh_sideband_check
`default_nettype wire

// [verification/sbh_bus_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sbh_bus_model
	import sbh_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic [3:0]            dly,
	input  wire sbh_pkg::sbh_ack_req_t ack_req,
	output var  logic                  ack_done
);
	logic [3:0] cnt_r;
	// the bus may take a while to grant the announce cycle
	always_ff @(posedge core_clk) begin
		ack_done <= 1'b0;
		if (rst || !ack_req.valid || ack_done) begin
			cnt_r <= 4'h0;
		end else if (cnt_r == dly) begin
			ack_done <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule : sbh_bus_model
`default_nettype wire

// [verification/sbh_sideband_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module sbh_sideband_tb_top;
	import sbh_pkg::*;
	logic core_clk, rst, mgmt_interrupt_req_n, clock_halt_req_n;
	logic deeper_halt_req_n, ack_done, save_done, handler_exit;
	logic snoop_req, intr_req, save_start, handler_fetch, exec_en;
	logic outputs_oe, snoop_resp, intr_service, in_handler_mode;
	sbh_ack_req_t ack_req;
	sbh_clk_en_t  clk_en;
	logic [3:0]   dly;
	int           err_total, compares;
	sbh_sideband i_sbh_sideband (.*);
	sbh_bus_model i_sbh_bus_model (.core_clk(core_clk), .rst(rst),
		.dly(dly), .ack_req(ack_req), .ack_done(ack_done));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tk
	task automatic do_rst(input logic m);
		@(posedge core_clk);
		rst <= 1'b1;
		mgmt_interrupt_req_n <= m;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		tk(4);
	endtask : do_rst
	task automatic t_float;
		chk(outputs_oe, 1'b1);
		do_rst(1'b0);
		chk(outputs_oe, 1'b0);
		@(posedge core_clk);
		mgmt_interrupt_req_n <= 1'b1;
		tk(8);
		chk(outputs_oe, 1'b0);
		do_rst(1'b1);
		chk(outputs_oe, 1'b1);
		$display("t_float done");
	endtask : t_float
	task automatic t_mgmt;
		@(posedge core_clk);
		mgmt_interrupt_req_n <= 1'b0;
		tk(3);
		chk({save_start, ack_req.valid}, 2'h2);
		@(posedge core_clk);
		save_done <= 1'b1;
		mgmt_interrupt_req_n <= 1'b1;
		tk(3);
		chk({ack_req, handler_fetch}, 4'hA);
		tk(4);
		chk({ack_req.valid, in_handler_mode}, 2'h1);
		@(posedge core_clk);
		handler_exit <= 1'b1;
		save_done <= 1'b0;
		@(posedge core_clk);
		handler_exit <= 1'b0;
		tk(3);
		chk({handler_fetch, in_handler_mode, exec_en}, 3'h1);
		$display("t_mgmt done");
	endtask : t_mgmt
	task automatic t_halt;
		@(posedge core_clk);
		dly <= 4'h5;
		clock_halt_req_n <= 1'b0;
		snoop_req <= 1'b1;
		intr_req <= 1'b1;
		tk(4);
		chk({ack_req, clk_en}, {1'b1, SBH_ACK_HALT, 3'h3});
		chk({snoop_resp, intr_service}, 2'h3);
		tk(10);
		@(posedge core_clk);
		deeper_halt_req_n <= 1'b0;
		tk(6);
		chk({clk_en, snoop_resp, intr_service}, 5'h00);
		@(posedge core_clk);
		deeper_halt_req_n <= 1'b1;
		tk(6);
		chk({clk_en, snoop_resp, intr_service}, 5'h0F);
		@(posedge core_clk);
		clock_halt_req_n <= 1'b1;
		tk(6);
		chk({clk_en, exec_en}, 4'hF);
		$display("t_halt done");
	endtask : t_halt
	task automatic conclude;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	initial begin
		tk(3000);
		err_total++;
		conclude();
	end
	initial begin
		{rst, mgmt_interrupt_req_n, clock_halt_req_n} = 3'h7;
		{deeper_halt_req_n, save_done, handler_exit} = 3'h4;
		{snoop_req, intr_req, dly} = 6'h02;
		err_total = 0;
		compares = 0;
		do_rst(1'b1);
		t_float();
		t_mgmt();
		t_halt();
		conclude();
	end
endmodule : sbh_sideband_tb_top
bind sbh_sideband sbh_sideband_check i_sbh_sideband_check (.*);
`default_nettype wire
